// file: design/sat_store_pkg.sv
// Shared constants for the saturating arithmetic and store slice
package sat_store_pkg;
    // Instruction word fields
    localparam int DST_LSB = 23;
    localparam int SRC2_LSB = 18;
    localparam int SRC1_LSB = 13;
    localparam int XBIT_POS = 12;
    localparam int SIDE_POS = 1;
    localparam int YBIT_POS = 7;
    localparam int MODE_LSB = 9;
    localparam int LDST_LSB = 4;
    // Format markers in the low bits
    localparam logic [3:0] S_FMT = 4'h8;
    localparam logic [2:0] L_FMT = 3'h6;
    localparam logic [1:0] ST_FMT = 2'h1;
    // Opfields
    localparam logic [5:0] OP_SHL_REG = 6'h23;
    localparam logic [5:0] OP_SHL_CST = 6'h22;
    localparam logic [6:0] OP_SUB_RX = 7'h0f;
    localparam logic [6:0] OP_SUB_XR = 7'h1f;
    localparam logic [6:0] OP_SUB_C = 7'h0e;
    localparam logic [6:0] OP_SUB_CL = 7'h2c;
    // Access type codes
    localparam logic [2:0] ACC_BYTE = 3'h3;
    localparam logic [2:0] ACC_HALF = 3'h5;
    localparam logic [2:0] ACC_WORD = 3'h7;
    // Saturation limits
    localparam logic [31:0] MAX32 = 32'h7fff_ffff;
    localparam logic [31:0] MIN32 = 32'h8000_0000;
    localparam logic [39:0] MAX40 = 40'h7f_ffff_ffff;
    localparam logic [39:0] MIN40 = 40'h80_0000_0000;
    // Addressing mode word layout
    localparam int AMR_BK0_LSB = 16;
    localparam int AMR_BK1_LSB = 21;
    localparam logic [1:0] AMR_CIRC0 = 2'h1;
    localparam logic [1:0] AMR_CIRC1 = 2'h2;
    // Reset values
    localparam logic [31:0] RF_RESET = 32'h0000_0000;
endpackage : sat_store_pkg

// file: design/sat_shift_unit.sv
// Saturating 32-bit left shift, purely combinational
`timescale 1ns/1ps
`default_nettype none
module sat_shift_unit (
    // Operands
    input wire logic [31:0] i_value,
    input wire logic [4:0] i_amount,
    // Result
    output logic [31:0] o_result,
    output logic o_sat
);
    logic [63:0] wide;
    logic [32:0] top;

    // Sign-extend so shifted-out bits can be compared with the new sign
    assign wide = {{32{i_value[31]}}, i_value} << i_amount;
    assign top = wide[63:31];
    assign o_sat = !((&top) || (~|top)); // [RL3]
    assign o_result = !o_sat ? wide[31:0] :
                      (i_value[31] ? sat_store_pkg::MIN32 : sat_store_pkg::MAX32); // [RL19]
endmodule : sat_shift_unit
`default_nettype wire

// file: design/store_addr_gen.sv
// Store address generator: scaling, linear or circular arithmetic
`timescale 1ns/1ps
`default_nettype none
module store_addr_gen (
    // Operands
    input wire logic [31:0] i_base,
    input wire logic [31:0] i_offset,
    input wire logic [1:0] i_scale,
    // Option bits
    input wire logic i_add,
    input wire logic i_post,
    input wire logic i_circ,
    input wire logic [4:0] i_block_exp,
    // Results
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_new_base
);
    logic [31:0] scaled;
    logic [31:0] linear;
    logic [32:0] mask33;
    logic [31:0] mask;

    // Offset is scaled by the access size
    assign scaled = i_offset << i_scale; // [RL11]
    assign linear = i_add ? i_base + scaled : i_base - scaled;
    // Circular block holds 2^(N+1) bytes; upper bits stay fixed
    assign mask33 = (33'h1 << ({1'b0, i_block_exp} + 6'h01)) - 33'h1;
    assign mask = mask33[31:0];
    assign o_new_base = i_circ ? ((i_base & ~mask) | (linear & mask)) : linear; // [RL14]
    assign o_mem_addr = i_post ? i_base : o_new_base; // [RL12] [RL13]
endmodule : store_addr_gen
`default_nettype wire

// file: design/sat_arith_store_datapath.sv
// Saturating shift, saturating subtract and indirect store slice
// Function
// RL1: Shift-left-saturate decoded from opfield 100011 (register) or 100010 (constant).
// RL2: Register shift amount uses only its five low bits, 0 to 31.
// RL3: Shift result clamps to signed 32-bit range when significant bits drop.
// RL4: Subtract computes first minus second operand, clamped to destination size.
// RL5: 32-bit difference clamps to 2^31-1 above and -2^31 below.
// RL6: 40-bit difference clamps to 2^39-1 above and -2^39 below.
// RL7: Any clamp sets saturation flag one cycle after destination write.
// RL8: Store address is base pointer plus index register or five-bit constant.
// RL9: Base and index come from the same file as the storing unit.
// RL10: Unit-select bit clear uses A file, set uses B file.
// RL11: Access type 011 byte, 101 halfword shift one, 111 word shift two.
// RL12: Offset and pre-modify forms send the computed sum to memory.
// RL13: Post-modify forms send old base, then write the modified base.
// RL14: Base A4-A7 or B4-B7 may use circular arithmetic per mode register.
// RL15: Byte and halfword store low 8 or 16 bits; word stores all 32.
// RL16: Side bit picks source file, independent of unit and address registers.
// RL17: Mode field decodes offset, pre and post forms, register or constant.
// RL18: False predicate means no write, no store, no update, no flag change.
// RL19: Clamped shift gives most positive or most negative value by sign.
`timescale 1ns/1ps
`default_nettype none
module sat_arith_store_datapath (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Instruction dispatch
    input wire logic i_instr_valid,
    input wire logic [31:0] i_instr,
    input wire logic i_cond_true,
    // Addressing mode register contents
    input wire logic [31:0] i_addressing_mode_register,
    // Saturation flag clear from the control-status register
    input wire logic i_sat_clear,
    // Register file loader
    input wire logic i_load_en,
    input wire logic i_load_side,
    input wire logic [4:0] i_load_idx,
    input wire logic [31:0] i_load_data,
    // Register file readback
    input wire logic i_rd_side,
    input wire logic [4:0] i_rd_idx,
    output logic [31:0] o_rd_data,
    // Data memory store port
    output logic o_mem_wr,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_data,
    output logic [3:0] o_mem_be,
    // Status
    output logic o_dst_wr,
    output logic o_saturation_flag
);
    // Register files, A and B
    logic [31:0] rf_a [0:31];
    logic [31:0] rf_b [0:31];

    // Field extraction
    wire [4:0] f_dst = i_instr[sat_store_pkg::DST_LSB +: 5];
    wire [4:0] f_src2 = i_instr[sat_store_pkg::SRC2_LSB +: 5];
    wire [4:0] f_src1 = i_instr[sat_store_pkg::SRC1_LSB +: 5];

    // Cross, side and unit-select bits
    wire f_x = i_instr[sat_store_pkg::XBIT_POS];
    wire f_s = i_instr[sat_store_pkg::SIDE_POS];
    wire f_y = i_instr[sat_store_pkg::YBIT_POS];

    // Store mode and access type
    wire [3:0] f_mode = i_instr[sat_store_pkg::MODE_LSB +: 4];
    wire [2:0] f_acc = i_instr[sat_store_pkg::LDST_LSB +: 3];

    // Arithmetic opfields
    wire [5:0] f_sop = i_instr[11:6];
    wire [6:0] f_lop = i_instr[11:5];

    // Format and opcode decode
    wire exec = i_instr_valid && i_cond_true; // [RL18]

    // Format markers in the low bits
    wire is_s = i_instr[5:2] == sat_store_pkg::S_FMT;
    wire is_l = i_instr[4:2] == sat_store_pkg::L_FMT;
    wire is_st = i_instr[3:2] == sat_store_pkg::ST_FMT;

    // Shift forms
    wire shl_reg = is_s && f_sop == sat_store_pkg::OP_SHL_REG; // [RL1]
    wire shl_cst = is_s && f_sop == sat_store_pkg::OP_SHL_CST; // [RL1]
    wire do_shl = shl_reg || shl_cst;

    // Subtract forms, one per operand kind
    wire sub_rx = is_l && f_lop == sat_store_pkg::OP_SUB_RX;
    wire sub_xr = is_l && f_lop == sat_store_pkg::OP_SUB_XR;
    wire sub_c = is_l && f_lop == sat_store_pkg::OP_SUB_C;
    wire sub_cl = is_l && f_lop == sat_store_pkg::OP_SUB_CL;
    wire do_sub = sub_rx || sub_xr || sub_c || sub_cl;

    // Operand reads; unit side from s, cross path from x
    wire [31:0] own_src1 = f_s ? rf_b[f_src1] : rf_a[f_src1];
    wire [31:0] own_src2 = f_s ? rf_b[f_src2] : rf_a[f_src2];

    // Cross path reads the other file
    wire [31:0] xs_src1 = (f_s ^ f_x) ? rf_b[f_src1] : rf_a[f_src1];
    wire [31:0] xs_src2 = (f_s ^ f_x) ? rf_b[f_src2] : rf_a[f_src2];

    // Odd partner of a long pair
    wire [4:0] src2_hi_idx = {f_src2[4:1], 1'b1};
    wire [31:0] own_src2_hi = f_s ? rf_b[src2_hi_idx] : rf_a[src2_hi_idx];

    // Shift path; register amount keeps only five low bits
    wire [4:0] shl_amt = shl_reg ? own_src1[4:0] : f_src1; // [RL2]
    wire [31:0] shl_res;
    wire shl_sat;

    sat_shift_unit u_shift (
        .i_value(xs_src2),
        .i_amount(shl_amt),
        .o_result(shl_res),
        .o_sat(shl_sat)
    );

    // Subtract operands; constant forms sign-extend the field
    wire [31:0] cst_sx = {{27{f_src1[4]}}, f_src1};
    wire [31:0] sub_a32 = sub_xr ? xs_src1 : ((sub_c || sub_cl) ? cst_sx : own_src1);
    wire [31:0] sub_b32 = sub_xr ? own_src2 : xs_src2;

    // Long pair: even register low word, odd register top byte
    wire [39:0] long_b = {own_src2_hi[7:0], own_src2};

    // Widened to 41 bits so the difference never wraps
    wire [40:0] op_a = {{9{sub_a32[31]}}, sub_a32};
    wire [40:0] op_b = sub_cl ? {long_b[39], long_b} : {{9{sub_b32[31]}}, sub_b32};
    wire [40:0] diff = op_a - op_b; // [RL4]

    // 32-bit clamp
    wire d32_hi = !diff[40] && (diff[39:31] != 9'h000);
    wire d32_lo = diff[40] && (diff[39:31] != 9'h1ff);
    wire [31:0] sub32 = d32_hi ? sat_store_pkg::MAX32 :
                        (d32_lo ? sat_store_pkg::MIN32 : diff[31:0]); // [RL5]

    // 40-bit clamp
    wire d40_hi = !diff[40] && diff[39];
    wire d40_lo = diff[40] && !diff[39];
    wire [39:0] sub40 = d40_hi ? sat_store_pkg::MAX40 :
                        (d40_lo ? sat_store_pkg::MIN40 : diff[39:0]); // [RL6]

    // Flag source follows the destination size
    wire sub_sat = sub_cl ? (d40_hi || d40_lo) : (d32_hi || d32_lo);

    // Store decode; undefined modes and access types store nothing
    wire mode_ok = !(f_mode[2] && !f_mode[3]) || f_mode[1] == 1'b0; // [RL17]
    wire mode_legal = f_mode[3] ? 1'b1 : !f_mode[1]; // [RL17]

    // Access type sets size and offset scaling
    wire acc_b = f_acc == sat_store_pkg::ACC_BYTE;
    wire acc_h = f_acc == sat_store_pkg::ACC_HALF;
    wire acc_w = f_acc == sat_store_pkg::ACC_WORD;
    wire do_st = is_st && mode_ok && mode_legal && (acc_b || acc_h || acc_w);
    wire [1:0] scale = acc_w ? 2'h2 : (acc_h ? 2'h1 : 2'h0); // [RL11]

    // Post forms send the old base
    wire st_post = f_mode[3] && f_mode[1]; // [RL13]
    wire st_modify = f_mode[3]; // [RL12] [RL13]

    // Address registers from the unit's own file, chosen by y
    wire [31:0] base_val = f_y ? rf_b[f_src2] : rf_a[f_src2]; // [RL9] [RL10]
    wire [31:0] idx_val = f_y ? rf_b[f_src1] : rf_a[f_src1]; // [RL9] [RL10]
    wire [31:0] offset_val = f_mode[2] ? idx_val : {27'h0, f_src1}; // [RL8]

    // Circular selection: two mode bits per base register A4-A7, B4-B7
    wire circ_reg = f_src2[4:2] == 3'h1; // [RL14]
    wire [3:0] amr_field = {f_y, f_src2[1:0], 1'b0};
    wire [1:0] amr_mode = i_addressing_mode_register[amr_field +: 2];
    wire circ_en = circ_reg && (amr_mode == sat_store_pkg::AMR_CIRC0 ||
                                amr_mode == sat_store_pkg::AMR_CIRC1); // [RL14]

    // Block size field named by the mode
    wire [4:0] blk_exp = amr_mode == sat_store_pkg::AMR_CIRC1 ?
        i_addressing_mode_register[sat_store_pkg::AMR_BK1_LSB +: 5] :
        i_addressing_mode_register[sat_store_pkg::AMR_BK0_LSB +: 5];

    // Address generator results
    wire [31:0] st_addr;
    wire [31:0] st_new_base;

    store_addr_gen u_agen (
        .i_base(base_val),
        .i_offset(offset_val),
        .i_scale(scale),
        .i_add(f_mode[0]),
        .i_post(st_post),
        .i_circ(circ_en),
        .i_block_exp(blk_exp),
        .o_mem_addr(st_addr),
        .o_new_base(st_new_base)
    );

    // Store source comes from the file named by s, not by y
    wire [31:0] st_src = f_s ? rf_b[f_dst] : rf_a[f_dst]; // [RL16]
    // Narrow data is replicated on all lanes; enables pick the lane
    wire [31:0] st_data = acc_w ? st_src :
                          (acc_h ? {2{st_src[15:0]}} : {4{st_src[7:0]}}); // [RL15]

    // Enables from the low address bits
    wire [3:0] be_byte = 4'h1 << st_addr[1:0];
    wire [3:0] be_half = st_addr[1] ? 4'hc : 4'h3;
    wire [3:0] st_be = acc_w ? 4'hf : (acc_h ? be_half : be_byte); // [RL15]

    // Write port 0 selection: instruction result, base update, or loader
    wire wr_shl = exec && do_shl;
    wire wr_sub = exec && do_sub;
    wire wr_base = exec && do_st && st_modify; // [RL13] [RL18]

    // Port 0 target: base, then result, then loader
    wire wr0_en = wr_shl || wr_sub || wr_base || i_load_en;
    wire wr0_side = wr_base ? f_y : ((wr_shl || wr_sub) ? f_s : i_load_side);
    wire [4:0] wr0_idx = wr_base ? f_src2 :
                         ((wr_shl || wr_sub) ? (sub_cl ? {f_dst[4:1], 1'b0} : f_dst) :
                          i_load_idx);
    wire [31:0] wr0_data = wr_base ? st_new_base :
                           (wr_shl ? shl_res :
                            (wr_sub ? (sub_cl ? sub40[31:0] : sub32) : i_load_data));
    // Port 1 carries the upper eight bits of a long result
    wire wr1_en = wr_sub && sub_cl;
    wire [4:0] wr1_idx = {f_dst[4:1], 1'b1};
    wire [31:0] wr1_data = {24'h00_0000, sub40[39:32]};

    // Clamp event, executed ops only
    wire sat_event = (wr_shl && shl_sat) || (wr_sub && sub_sat); // [RL18]

    // Register files; instruction writes take priority over the loader
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 32; i++) begin
                rf_a[i] <= sat_store_pkg::RF_RESET;
                rf_b[i] <= sat_store_pkg::RF_RESET;
            end
        end else begin
            if (wr0_en && !wr0_side) begin
                rf_a[wr0_idx] <= wr0_data;
            end
            if (wr0_en && wr0_side) begin
                rf_b[wr0_idx] <= wr0_data;
            end
            if (wr1_en && !f_s) begin
                rf_a[wr1_idx] <= wr1_data;
            end
            if (wr1_en && f_s) begin
                rf_b[wr1_idx] <= wr1_data;
            end
        end
    end

    // Memory store port, one-cycle write strobe
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mem_wr <= 1'b0;
            o_mem_addr <= 32'h0000_0000;
            o_mem_data <= 32'h0000_0000;
            o_mem_be <= 4'h0;
        end else begin
            o_mem_wr <= exec && do_st; // [RL18]
            o_mem_addr <= st_addr; // [RL12] [RL13]
            o_mem_data <= st_data; // [RL15]
            o_mem_be <= (exec && do_st) ? st_be : 4'h0;
        end
    end

    // Saturation: pend at the write edge, flag one cycle later
    logic sat_pend_r;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sat_pend_r <= 1'b0;
        end else begin
            sat_pend_r <= sat_event; // [RL7]
        end
    end

    // Sticky flag; a new clamp beats a same-cycle clear so no event is lost
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_saturation_flag <= 1'b0;
        end else begin
            o_saturation_flag <= sat_pend_r || (o_saturation_flag && !i_sat_clear); // [RL7]
        end
    end

    // Readback, one cycle behind the select
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= 32'h0000_0000;
        end else begin
            o_rd_data <= i_rd_side ? rf_b[i_rd_idx] : rf_a[i_rd_idx];
        end
    end

    // Destination-write pulse, at the edge of the write
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dst_wr <= 1'b0;
        end else begin
            o_dst_wr <= wr_shl || wr_sub;
        end
    end
endmodule : sat_arith_store_datapath
`default_nettype wire

// file: testbench/arith_store_monitor.sv
// Port checker for the saturating arithmetic and store slice
`timescale 1ns/1ps
`default_nettype none
module arith_store_monitor (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Instruction side
    input wire logic i_instr_valid,
    input wire logic [31:0] i_instr,
    input wire logic i_cond_true,
    input wire logic i_sat_clear,
    // Store port and status
    input wire logic o_mem_wr,
    input wire logic [31:0] o_mem_addr,
    input wire logic [31:0] o_mem_data,
    input wire logic [3:0] o_mem_be,
    input wire logic o_dst_wr,
    input wire logic o_saturation_flag
);
    // Decode of accepted instructions; refused store modes have bit 3 clear and bit 1 set
    logic shl_dec;
    logic sub_dec;
    logic st_dec;
    assign shl_dec = i_instr[5:2] == sat_store_pkg::S_FMT
        && i_instr[11:6] inside {sat_store_pkg::OP_SHL_REG, sat_store_pkg::OP_SHL_CST};
    assign sub_dec = i_instr[4:2] == sat_store_pkg::L_FMT && i_instr[11:5] inside
        {sat_store_pkg::OP_SUB_RX, sat_store_pkg::OP_SUB_XR, sat_store_pkg::OP_SUB_C,
        sat_store_pkg::OP_SUB_CL};
    assign st_dec = i_instr[3:2] == sat_store_pkg::ST_FMT && !(!i_instr[12] && i_instr[10])
        && i_instr[6:4] inside {sat_store_pkg::ACC_BYTE, sat_store_pkg::ACC_HALF,
        sat_store_pkg::ACC_WORD};

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    // Strobes only follow an executed, recognised instruction
    a_store_cause: assert property (o_mem_wr |-> $past(i_instr_valid && i_cond_true && st_dec))
        else $error("store strobe without an executed store");
    a_dst_cause: assert property (o_dst_wr |-> $past(i_instr_valid && i_cond_true && (shl_dec || sub_dec)))
        else $error("destination write without an executed shift or subtract");
    a_pred_quiet: assert property (i_instr_valid && !i_cond_true |=> !o_mem_wr && !o_dst_wr)
        else $error("false predicate produced activity");
    // Lane and size relations on the store port
    a_idle_lanes: assert property (!o_mem_wr |-> o_mem_be == 4'h0)
        else $error("byte enables active without a store");
    a_store_size: assert property (o_mem_wr |-> $countones(o_mem_be) ==
        ($past(i_instr[6:4]) == sat_store_pkg::ACC_BYTE ? 1 :
        $past(i_instr[6:4]) == sat_store_pkg::ACC_HALF ? 2 : 4))
        else $error("store width does not match access type");
    a_byte_lane: assert property (o_mem_wr && $countones(o_mem_be) == 1 |->
        o_mem_be == 4'h1 << o_mem_addr[1:0] && o_mem_data == {4{o_mem_data[7:0]}})
        else $error("byte store lane or data wrong");
    a_half_lane: assert property (o_mem_wr && $countones(o_mem_be) == 2 |->
        o_mem_be[3] == o_mem_addr[1] && o_mem_data[31:16] == o_mem_data[15:0])
        else $error("halfword store lane or data wrong");
    // Flag sets one cycle after the write and is sticky until cleared
    a_flag_rise: assert property ($rose(o_saturation_flag) |-> $past(o_dst_wr))
        else $error("flag set without a preceding destination write");
    a_flag_hold: assert property ($fell(o_saturation_flag) |-> $past(i_sat_clear))
        else $error("flag dropped without a clear");
endmodule : arith_store_monitor

bind sat_arith_store_datapath arith_store_monitor u_monitor (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .i_cond_true(i_cond_true), .i_sat_clear(i_sat_clear), .o_mem_wr(o_mem_wr),
    .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data), .o_mem_be(o_mem_be),
    .o_dst_wr(o_dst_wr), .o_saturation_flag(o_saturation_flag));
`default_nettype wire

// file: testbench/store_port_model.sv
// Data memory store port model: counts stores and keeps the last address
`timescale 1ns/1ps
`default_nettype none
module store_port_model (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Store port from the slice
    input wire logic i_mem_wr,
    input wire logic [31:0] i_mem_addr,
    input wire logic [3:0] i_mem_be,
    // Observation
    output logic [7:0] o_store_count,
    output logic [31:0] o_last_addr
);
    // Accepts every strobe with a nonzero byte enable at once; this port has no wait states
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_store_count <= 8'h00;
            o_last_addr <= 32'h0000_0000;
        end else if (i_mem_wr && i_mem_be != 4'h0) begin
            o_store_count <= o_store_count + 8'h01;
            o_last_addr <= i_mem_addr;
        end
    end
endmodule : store_port_model
`default_nettype wire

// file: testbench/test_sat_arith_store_datapath.sv
// Directed testbench for the saturating arithmetic and store slice
`timescale 1ns/1ps
`default_nettype none
module test_sat_arith_store_datapath;
    // Stimulus and observed signals
    logic i_core_clk = 0, i_rst_n = 0, i_instr_valid = 0, i_cond_true = 0, i_sat_clear = 0;
    logic i_load_en = 0, i_load_side = 0, i_rd_side = 0;
    logic [4:0] i_load_idx = 0, i_rd_idx = 0;
    logic [31:0] i_instr = 0, mode_word = 0, i_load_data = 0;
    logic [31:0] o_rd_data, o_mem_addr, o_mem_data, last_addr;
    logic [3:0] o_mem_be;
    logic o_mem_wr, o_dst_wr, o_saturation_flag;
    logic [7:0] st_cnt;
    logic [3:0] modes [12] = '{4'h5, 4'h4, 4'hd, 4'hc, 4'hf, 4'he, 4'h1, 4'h0, 4'h9, 4'h8, 4'hb, 4'ha};
    logic [2:0] accs [3] = '{sat_store_pkg::ACC_BYTE, sat_store_pkg::ACC_HALF, sat_store_pkg::ACC_WORD};
    int mismatches = 0, cmp_count = 0;
    always #10 i_core_clk = ~i_core_clk;
    sat_arith_store_datapath dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_cond_true(i_cond_true),
        .i_addressing_mode_register(mode_word), .i_sat_clear(i_sat_clear), .i_load_en(i_load_en),
        .i_load_side(i_load_side), .i_load_idx(i_load_idx), .i_load_data(i_load_data),
        .i_rd_side(i_rd_side), .i_rd_idx(i_rd_idx), .o_rd_data(o_rd_data), .o_mem_wr(o_mem_wr),
        .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data), .o_mem_be(o_mem_be),
        .o_dst_wr(o_dst_wr), .o_saturation_flag(o_saturation_flag));
    store_port_model mdl (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_mem_wr(o_mem_wr),
        .i_mem_addr(o_mem_addr), .i_mem_be(o_mem_be), .o_store_count(st_cnt),
        .o_last_addr(last_addr));
    // Comparison and closing
    task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim
    // Instruction words, A-file unit side for arithmetic, store unit side from y; store source is always register 1 of the other side
    function automatic logic [31:0] s_op(logic [5:0] op, logic [4:0] d, s2, s1);
        return {4'h0, d, s2, s1, 1'b0, op, sat_store_pkg::S_FMT, 2'h0};
    endfunction : s_op
    function automatic logic [31:0] l_op(logic [6:0] op, logic [4:0] d, s2, s1);
        return {4'h0, d, s2, s1, 1'b0, op, sat_store_pkg::L_FMT, 2'h0};
    endfunction : l_op
    function automatic logic [31:0] st_op(logic [4:0] b, o, logic [3:0] m, logic y, logic [2:0] a);
        return {4'h0, 5'h01, b, o, m, 1'b0, y, a, sat_store_pkg::ST_FMT, ~y, 1'b0};
    endfunction : st_op
    // Access tasks: loader, readback, instruction issue
    task automatic ld(input logic sd, input logic [4:0] ix, input logic [31:0] val);
        @(posedge i_core_clk) {i_load_en, i_load_side, i_load_idx, i_load_data} <= {1'b1, sd, ix, val};
        @(posedge i_core_clk) i_load_en <= 1'b0;
    endtask : ld
    task automatic rdchk(input logic sd, input logic [4:0] ix, input string nm, input logic [31:0] e);
        @(posedge i_core_clk) {i_rd_side, i_rd_idx} <= {sd, ix};
        @(posedge i_core_clk) #1;
        check(nm, o_rd_data, e);
    endtask : rdchk
    task automatic ex(input logic [31:0] w, input logic c);
        @(posedge i_core_clk) {i_instr_valid, i_instr, i_cond_true} <= {1'b1, w, c};
        @(posedge i_core_clk) i_instr_valid <= 1'b0;
        #1;
    endtask : ex
    // Arithmetic op: write strobe now, flag one cycle later, then clear the flag
    task automatic op(input logic [31:0] w, input logic c, input logic ew, input logic ef);
        ex(w, c);
        check("dst_wr", o_dst_wr, ew);
        @(posedge i_core_clk) #1;
        check("flag", o_saturation_flag, ef);
        @(posedge i_core_clk) i_sat_clear <= 1'b1;
        @(posedge i_core_clk) i_sat_clear <= 1'b0;
    endtask : op
    // Generous ceiling; the sequence needs under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_core_clk);
        mismatches++;
        end_sim();
    end
    initial begin
        logic [31:0] d, nb, ea, sv;
        repeat (20) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        ld(0, 1, 32'h02e3_031c);
        ld(0, 2, 32'h0000_0022);
        ld(0, 4, 32'h4000_0000);
        ld(0, 6, 32'h8000_0001);
        op(s_op(sat_store_pkg::OP_SHL_REG, 3, 1, 2), 1, 1, 0);
        rdchk(0, 3, "shl_reg", 32'h0b8c_0c70);
        op(s_op(sat_store_pkg::OP_SHL_CST, 5, 4, 1), 1, 1, 1);
        rdchk(0, 5, "shl_pos", sat_store_pkg::MAX32);
        op(s_op(sat_store_pkg::OP_SHL_CST, 7, 6, 4), 1, 1, 1);
        rdchk(0, 7, "shl_neg", sat_store_pkg::MIN32);
        ld(0, 8, 32'h7fff_ffff);
        ld(0, 9, 32'hffff_ffff);
        ld(0, 11, 32'h8000_0000);
        ld(0, 12, 32'h0000_0001);
        op(l_op(sat_store_pkg::OP_SUB_RX, 10, 9, 8), 1, 1, 1);
        rdchk(0, 10, "sub_hi", sat_store_pkg::MAX32);
        op(l_op(sat_store_pkg::OP_SUB_RX, 13, 12, 11), 1, 1, 1);
        rdchk(0, 13, "sub_lo", sat_store_pkg::MIN32);
        op(l_op(sat_store_pkg::OP_SUB_XR, 14, 12, 9), 1, 1, 0);
        rdchk(0, 14, "sub_xr", 32'hffff_fffe);
        op(l_op(sat_store_pkg::OP_SUB_C, 15, 8, 5'h1f), 1, 1, 0);
        rdchk(0, 15, "sub_edge", 32'h8000_0000);
        ld(0, 16, 32'h0000_0000);
        ld(0, 17, 32'h0000_0080);
        op(l_op(sat_store_pkg::OP_SUB_CL, 18, 16, 5'h01), 1, 1, 1);
        rdchk(0, 18, "long_hi_lo", 32'hffff_ffff);
        rdchk(0, 19, "long_hi_hi", 32'h0000_007f);
        ld(0, 16, 32'hffff_ffff);
        ld(0, 17, 32'h0000_007f);
        op(l_op(sat_store_pkg::OP_SUB_CL, 18, 16, 5'h1e), 1, 1, 1);
        rdchk(0, 18, "long_lo_lo", 32'h0000_0000);
        rdchk(0, 19, "long_lo_hi", 32'h0000_0080);
        op(s_op(sat_store_pkg::OP_SHL_CST, 20, 4, 1), 0, 0, 0);
        rdchk(0, 20, "nop_dst", 32'h0000_0000);
        $display("shift and subtract test done");
        // Every mode and access type; unit side alternates, source from the other side
        ld(0, 1, 32'h1234_5678);
        ld(1, 1, 32'h9abc_def0);
        for (int i = 0; i < 36; i++) begin
            d = 32'h0000_0003 << (i / 12);
            nb = modes[i % 12][0] ? 32'h0000_1000 + d : 32'h0000_1000 - d;
            ea = modes[i % 12][1] ? 32'h0000_1000 : nb;
            sv = i[0] ? 32'h1234_5678 : 32'h9abc_def0;
            ld(i[0], 10, 32'h0000_1000);
            ld(i[0], 3, 32'h0000_0003);
            ex(st_op(10, 3, modes[i % 12], i[0], accs[i / 12]), 1);
            check("mem_wr", o_mem_wr, 1);
            check("mem_addr", o_mem_addr, ea);
            check("mem_data", o_mem_data, i < 12 ? {4{sv[7:0]}} : i < 24 ? {2{sv[15:0]}} : sv);
            check("mem_be", o_mem_be, i < 12 ? 4'h1 << ea[1:0] : i < 24 ? (ea[1] ? 4'hc : 4'h3) : 4'hf);
            rdchk(i[0], 10, "base", modes[i % 12][3] ? nb : 32'h0000_1000);
        end
        $display("store modes test done");
        op(l_op(sat_store_pkg::OP_SUB_RX, 21, 1, 8) | 32'h0000_1000, 1, 1, 1);
        rdchk(0, 21, "sub_cross", sat_store_pkg::MAX32);
        @(posedge i_core_clk) mode_word <= 32'h0003_0001;
        ld(0, 4, 32'h0000_100c);
        ex(st_op(4, 1, 4'hb, 0, sat_store_pkg::ACC_WORD), 1);
        check("circ_addr", o_mem_addr, 32'h0000_100c);
        rdchk(0, 4, "circ_base", 32'h0000_1000);
        check("mdl_addr", last_addr, 32'h0000_100c);
        $display("circular test done");
        ex(st_op(10, 3, 4'hd, 0, sat_store_pkg::ACC_WORD), 0);
        check("nop_store", o_mem_wr, 0);
        rdchk(0, 10, "nop_base", 32'h0000_100c);
        check("store_count", st_cnt, 37);
        $display("false predicate test done");
        end_sim();
    end
endmodule : test_sat_arith_store_datapath
`default_nettype wire
